/* pnp_iso_pkg.sv */
// Purpose: shared constants for the card-side isolation logic
// Assumes: single clock domain, mclk
// Notes: key tables hold byte 0 in the low bits
package pnp_iso_pkg;

  // ==========================================================
  // card states
  typedef enum logic [1:0] {
    ST_WAIT_KEY,
    ST_SLEEP,
    ST_ISOLATE,
    ST_CONFIG
  } card_state_e;

  // ==========================================================
  // identifier layout
  localparam logic [6:0] ID_BITS = 7'h48;
  localparam logic [6:0] SUM_BITS = 7'h40;
  localparam logic [7:0] LFSR_SEED = 8'h6A;
  localparam logic [7:0] RESP_FIRST = 8'h55;
  localparam logic [7:0] RESP_SECOND = 8'hAA;
  localparam logic [1:0] SENSE_FIRST = 2'h1;
  localparam logic [1:0] SENSE_SECOND = 2'h2;
  localparam logic [7:0] CSN_NONE = 8'h00;
  localparam logic [7:0] WAKE_ISOLATE = 8'h00;

  // ==========================================================
  // unlock sequences
  localparam logic [5:0] KEY_LEN = 6'h20;
  localparam logic [255:0] STD_KEY = {
    64'h3973E7CE9D3A74E8, 64'hD1A2458B162C58B0,
    64'h61C3860D1B376FDF, 64'hBE7DFBF6EDDAB56A};
  localparam logic [255:0] VENDOR_KEY = {
    64'h50A143860C193265, 64'hCA942851A2448913,
    64'h264D9A3469D2A448, 64'h9123468D1B366DDA};

endpackage

/* pnp_isolation.sv */
// Purpose: plug and play isolation, checksum and card state logic
// Assumes: commands pre-decoded into one-cycle pulses on mclk; rst is bus reset drive
// Notes: ior_n and sd_in are bus pins and are filtered through three flops
`timescale 1ns/1ns
`default_nettype none

module pnp_isolation
  import pnp_iso_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ior_n,
  input wire logic [7:0] sd_in,
  output logic [7:0] sd_out,
  output logic sd_oe,
  input wire logic read_data_sel,
  input wire logic addr_wr,
  input wire logic [7:0] wr_data,
  input wire logic pnp_mode,
  input wire logic wake_cmd,
  input wire logic csn_wr,
  input wire logic wait_key_cmd,
  input wire logic reset_csn_cmd,
  input wire logic vendor_select_number_clear,
  input wire logic [63:0] serial_id_in,
  input wire logic ready_req,
  output logic iochrdy_oe,
  output logic [7:0] csn,
  output logic [1:0] card_state,
  output logic cmd_enable,
  output logic id_valid
);

  // ==========================================================
  // pin filters
  // the first stage may go metastable, so a level counts only once
  // the second and third stage agree
  logic [2:0] ior_sync_reg;
  logic [2:0] ior_sync_next;
  logic ior_filt_reg;
  logic ior_filt_next;
  logic [7:0] sd_filt_reg;

  always_comb begin
    ior_sync_next = {ior_sync_reg[1:0], ior_n};
    ior_filt_next = ior_filt_reg;
    if (ior_sync_reg[1] == ior_sync_reg[2]) begin
      ior_filt_next = ior_sync_reg[2];
    end
  end

  // idle strobe level after reset, so no false read edge follows it
  always_ff @(posedge mclk) begin
    if (rst) begin
      ior_sync_reg <= 3'h7;
      ior_filt_reg <= 1'b1;
    end else begin
      ior_sync_reg <= ior_sync_next;
      ior_filt_reg <= ior_filt_next;
    end
  end

  // one identical filter per data line
  for (genvar g = 0; g < 8; g++) begin : g_sd_filt
    logic [2:0] sd_sync_reg;
    logic [2:0] sd_sync_next;
    logic sd_bit_reg;
    logic sd_bit_next;

    always_comb begin
      sd_sync_next = {sd_sync_reg[1:0], sd_in[g]};
      sd_bit_next = sd_bit_reg;
      if (sd_sync_reg[1] == sd_sync_reg[2]) begin
        sd_bit_next = sd_sync_reg[2];
      end
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        sd_sync_reg <= 3'h0;
        sd_bit_reg <= 1'b0;
      end else begin
        sd_sync_reg <= sd_sync_next;
        sd_bit_reg <= sd_bit_next;
      end
    end

    assign sd_filt_reg[g] = sd_bit_reg;
  end

  wire logic rd_start = ior_filt_reg & ~ior_filt_next & read_data_sel;
  wire logic rd_end = ~ior_filt_reg & ior_filt_next;

  // ==========================================================
  // card state and isolation
  card_state_e state_reg, state_next;
  logic [7:0] csn_reg, csn_next;
  logic [5:0] key_std_reg, key_std_next;
  logic [5:0] key_ven_reg, key_ven_next;
  logic [6:0] bit_idx_reg, bit_idx_next;
  logic [7:0] lfsr_reg, lfsr_next;
  logic [7:0] chk_reg, chk_next;
  logic phase_reg, phase_next;
  logic saw_first_reg, saw_first_next;
  logic in_read_reg, in_read_next;
  logic [7:0] sd_out_reg, sd_out_next;
  logic sd_oe_reg, sd_oe_next;
  logic cur_bit;
  logic fb_bit;
  logic [71:0] full_id;

  // checksum field taken from the frozen copy chk_reg once 64 bits are past
  assign full_id = {chk_reg, serial_id_in};
  // identifier byte 0 bit 0 sits at index 0, so a rising index is lsb first
  // past the last bit the index points nowhere; read a quiet zero
  always_comb begin
    if (bit_idx_reg < ID_BITS) begin
      cur_bit = full_id[bit_idx_reg];
    end else begin
      cur_bit = 1'b0;
    end
  end
  assign fb_bit = lfsr_reg[1] ^ lfsr_reg[0] ^ cur_bit;

  always_comb begin
    state_next = state_reg;
    csn_next = csn_reg;
    key_std_next = key_std_reg;
    key_ven_next = key_ven_reg;
    bit_idx_next = bit_idx_reg;
    lfsr_next = lfsr_reg;
    chk_next = chk_reg;
    phase_next = phase_reg;
    saw_first_next = saw_first_reg;
    in_read_next = in_read_reg;
    sd_out_next = sd_out_reg;
    sd_oe_next = sd_oe_reg;

    // unlock sequence watch; a wrong byte restarts the match
    if (addr_wr) begin
      if (pnp_mode && wr_data == STD_KEY[{key_std_reg[4:0], 3'h0} +: 8]) begin
        key_std_next = key_std_reg + 6'h01;
      end else begin
        key_std_next = 6'h00;
      end
      if (wr_data == VENDOR_KEY[{key_ven_reg[4:0], 3'h0} +: 8]) begin
        key_ven_next = key_ven_reg + 6'h01;
      end else begin
        key_ven_next = 6'h00;
      end
    end

    case (state_reg)
      ST_WAIT_KEY: begin
        // every configuration command is ignored here
        if (key_std_reg == KEY_LEN || key_ven_reg == KEY_LEN) begin
          state_next = ST_SLEEP;
          key_std_next = 6'h00;
          key_ven_next = 6'h00;
        end
      end
      ST_SLEEP, ST_CONFIG: begin
        key_std_next = 6'h00;
        key_ven_next = 6'h00;
      end
      ST_ISOLATE: begin
        key_std_next = 6'h00;
        key_ven_next = 6'h00;
        if (rd_start && bit_idx_reg < ID_BITS) begin
          in_read_next = 1'b1;
          if (cur_bit) begin
            sd_oe_next = 1'b1;
            sd_out_next = phase_reg ? RESP_SECOND : RESP_FIRST;
          end
        end
        if (rd_end && in_read_reg) begin
          in_read_next = 1'b0;
          sd_oe_next = 1'b0;
          phase_next = ~phase_reg;
          if (!phase_reg) begin
            // only the two low lines are compared
            saw_first_next = !sd_oe_reg && sd_filt_reg[1:0] == SENSE_FIRST;
          end else if (!sd_oe_reg && saw_first_reg &&
                       sd_filt_reg[1:0] == SENSE_SECOND) begin
            state_next = ST_SLEEP;
            saw_first_next = 1'b0;
          end else begin
            saw_first_next = 1'b0;
            bit_idx_next = bit_idx_reg + 7'h01;
            if (bit_idx_reg < SUM_BITS) begin
              lfsr_next = {fb_bit, lfsr_reg[7:1]};
            end
            if (bit_idx_reg == SUM_BITS - 7'h01) begin
              // freeze the finished sum so the last pairs replay it
              chk_next = {fb_bit, lfsr_reg[7:1]};
            end
          end
        end
        if (csn_wr) begin
          csn_next = wr_data;
          state_next = ST_CONFIG;
        end
      end
      default: begin
        state_next = ST_WAIT_KEY;
      end
    endcase

    // wake commands act in every unlocked state
    if (wake_cmd && state_reg != ST_WAIT_KEY) begin
      lfsr_next = LFSR_SEED;
      bit_idx_next = 7'h00;
      phase_next = 1'b0;
      saw_first_next = 1'b0;
      in_read_next = 1'b0;
      sd_oe_next = 1'b0;
      if (wr_data == WAKE_ISOLATE && csn_reg == CSN_NONE) begin
        state_next = ST_ISOLATE;
      end else if (wr_data != WAKE_ISOLATE && wr_data == csn_reg) begin
        state_next = ST_CONFIG;
      end else begin
        state_next = ST_SLEEP;
      end
    end

    // number resets leave the state alone
    if ((reset_csn_cmd || vendor_select_number_clear) && state_reg != ST_WAIT_KEY) begin
      csn_next = CSN_NONE;
    end

    if (wait_key_cmd && state_reg != ST_WAIT_KEY) begin
      state_next = ST_WAIT_KEY;
      sd_oe_next = 1'b0;
      in_read_next = 1'b0;
    end

    // leaving isolation must never leave the bus driven
    if (state_next != ST_ISOLATE) begin
      sd_oe_next = 1'b0;
      in_read_next = 1'b0;
      phase_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_WAIT_KEY;
      csn_reg <= CSN_NONE;
      key_std_reg <= 6'h00;
      key_ven_reg <= 6'h00;
      bit_idx_reg <= 7'h00;
      lfsr_reg <= LFSR_SEED;
      chk_reg <= 8'h00;
      phase_reg <= 1'b0;
      saw_first_reg <= 1'b0;
      in_read_reg <= 1'b0;
      sd_out_reg <= 8'h00;
      sd_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      csn_reg <= csn_next;
      key_std_reg <= key_std_next;
      key_ven_reg <= key_ven_next;
      bit_idx_reg <= bit_idx_next;
      lfsr_reg <= lfsr_next;
      chk_reg <= chk_next;
      phase_reg <= phase_next;
      saw_first_reg <= saw_first_next;
      in_read_reg <= in_read_next;
      sd_out_reg <= sd_out_next;
      sd_oe_reg <= sd_oe_next;
    end
  end

  // ==========================================================
  // outputs
  assign sd_out = sd_out_reg;
  assign sd_oe = sd_oe_reg;
  assign csn = csn_reg;
  assign card_state = state_reg;
  // other commands wait for a number and the config state
  assign cmd_enable = (state_reg == ST_CONFIG) && (csn_reg != CSN_NONE);
  // wait states would stall the host's lock-step read pairs
  assign iochrdy_oe = ready_req && (state_reg != ST_ISOLATE);
  assign id_valid = |serial_id_in;

endmodule
`default_nettype wire

/* pnp_isolation_props.sv */
// Purpose: port checker for the isolation logic
// Assumes: one clock, rst synchronous active high
// Notes: bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module pnp_isolation_props
  import pnp_iso_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic addr_wr,
  input wire logic [7:0] wr_data,
  input wire logic wake_cmd,
  input wire logic csn_wr,
  input wire logic wait_key_cmd,
  input wire logic reset_csn_cmd,
  input wire logic vendor_select_number_clear,
  input wire logic ready_req,
  input wire logic [7:0] sd_out,
  input wire logic sd_oe,
  input wire logic iochrdy_oe,
  input wire logic [7:0] csn,
  input wire logic [1:0] card_state,
  input wire logic cmd_enable
);
  // ==========================================================
  // properties
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wake(d);
    card_state == 2'h1 && wake_cmd && wr_data == d && !wait_key_cmd;
  endsequence
  AST_RST: assert property (disable iff (1'b0) rst |=> !card_state && csn == CSN_NONE)
    else $error("reset left state or number");
  AST_WAITKEY: assert property (wait_key_cmd |=> card_state == 2'h0)
    else $error("wait-for-key command ignored");
  AST_NO_RDY: assert property (card_state == 2'h2 |-> !iochrdy_oe)
    else $error("wait-ready driven in isolation");
  AST_DRIVE: assert property (sd_oe |-> sd_out == RESP_FIRST || sd_out == RESP_SECOND)
    else $error("bad isolation byte");
  AST_WAKE_ISO: assert property (s_wake(WAKE_ISOLATE) ##0 csn == CSN_NONE |=> card_state == 2'h2)
    else $error("wake zero missed isolation");
  AST_WAKE_OWN: assert property (s_wake(csn) ##0 csn != CSN_NONE |=> card_state == 2'h3)
    else $error("wake own number missed config");
  AST_CSN_WR: assert property (card_state == 2'h2 && csn_wr && wr_data != CSN_NONE && !wake_cmd
    && !wait_key_cmd && !reset_csn_cmd && !vendor_select_number_clear
    |=> card_state == 2'h3 && csn == $past(wr_data))
    else $error("number write missed");
  AST_CLR: assert property ((reset_csn_cmd || vendor_select_number_clear) && card_state != 2'h0
    && !wake_cmd && !wait_key_cmd && !csn_wr |=> !csn && $stable(card_state))
    else $error("number reset wrong");
  AST_ISO_NUM: assert property (card_state == 2'h2 |-> csn == CSN_NONE)
    else $error("numbered card in isolation");
  AST_KEYWAIT: assert property ((card_state == 2'h0 && !addr_wr) [*2] |=> card_state == 2'h0)
    else $error("left wait-for-key without key");
  AST_CMD_EN: assert property (cmd_enable |-> card_state == 2'h3 && csn != CSN_NONE)
    else $error("commands enabled too early");
endmodule
`default_nettype wire

/* pnp_host_model.sv */
// Purpose: host doing isolation read pairs, plus a rival card
// Assumes: data lines have pull-ups, drivers wire-and
// Notes: pair gaps shortened, the card does not time them
`timescale 1ns/1ns
`default_nettype none
module pnp_host_model
  import pnp_iso_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] sd_out,
  input wire logic sd_oe,
  output logic ior_n,
  output logic [7:0] sd_in,
  output logic read_data_sel
);
  logic rival;
  logic [7:0] pat;
  // ==========================================================
  // bus level
  initial begin
    ior_n = 1;
    read_data_sel = 0;
    rival = 0;
    pat = 8'hFF;
  end
  always_comb begin
    sd_in = (sd_oe ? sd_out : 8'hFF) & (rival && !ior_n ? pat : 8'hFF);
  end
  task automatic read_one(input logic [7:0] p, output logic [7:0] d);
    @(posedge mclk) #2;
    pat = p;
    read_data_sel = 1;
    ior_n = 0;
    repeat (8) @(posedge mclk);
    d = sd_in;
    #2 ior_n = 1;
    repeat (8) @(posedge mclk);
    #2 read_data_sel = 0;
  endtask
  task automatic read_pair(input logic other, output logic one);
    logic [7:0] d0;
    logic [7:0] d1;
    rival = other;
    read_one(RESP_FIRST, d0);
    read_one(RESP_SECOND, d1);
    rival = 0;
    one = d0 === RESP_FIRST && d1 === RESP_SECOND;
  endtask
endmodule
`default_nettype wire

/* pnp_isolation_bench.sv */
// Purpose: self-checking bench for the isolation logic
// Assumes: commands are one-cycle pulses
// Notes: checksum worked out here from the seed
`timescale 1ns/1ns
`default_nettype none
module pnp_isolation_bench
  import pnp_iso_pkg::*;
;
  logic mclk, rst, ior_n, sd_oe, read_data_sel, addr_wr, pnp_mode, wake_cmd, csn_wr;
  logic wait_key_cmd, reset_csn_cmd, vendor_select_number_clear, ready_req, iochrdy_oe;
  logic cmd_enable, id_valid, b;
  logic [7:0] sd_in, sd_out, wr_data, csn;
  logic [1:0] card_state;
  logic [63:0] serial_id_in;
  logic [71:0] exp_id;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  pnp_isolation dut (.*);
  pnp_host_model host (.*);
  // ==========================================================
  // helpers
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s, input logic [7:0] d);
    wr_data = d;
    s = 1;
    @(posedge mclk) #2 s = 0;
    @(posedge mclk) #2;
  endtask
  task automatic send_key(input logic [255:0] k, input int n);
    for (int i = 0; i < n; i++) pulse(addr_wr, k[8*i +: 8]);
    @(posedge mclk) #2;
  endtask
  function automatic logic [71:0] ident(input logic [63:0] s);
    logic [7:0] l;
    l = LFSR_SEED;
    for (int i = 0; i < 64; i++) l = {l[1] ^ l[0] ^ s[i], l[7:1]};
    return {l, s};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_unlock();
    chk8({6'h0, card_state}, 8'h00);
    chk8({7'h0, id_valid}, 8'h01);
    pulse(wake_cmd, 8'h00);
    chk8({6'h0, card_state}, 8'h00);
    send_key(STD_KEY, 5);
    pulse(addr_wr, 8'h00);
    chk8({6'h0, card_state}, 8'h00);
    send_key(STD_KEY, 32);
    chk8({6'h0, card_state}, 8'h01);
    pulse(csn_wr, 8'h07);
    chk8(csn, 8'h00);
  endtask
  task automatic t_win();
    logic [71:0] rx;
    logic [71:0] sum_rx;
    pulse(wake_cmd, 8'h00);
    chk8({6'h0, card_state}, 8'h02);
    chk8({7'h0, iochrdy_oe}, 8'h00);
    for (int i = 0; i < 72; i++) begin
      host.read_pair(1'b0, b);
      chk8({7'h0, b}, {7'h0, exp_id[i]});
      rx[i] = b;
    end
    sum_rx = ident(rx[63:0]);
    chk8(rx[71:64], sum_rx[71:64]);
    pulse(csn_wr, 8'h05);
    chk8(csn, 8'h05);
    chk8({4'h0, card_state, cmd_enable, iochrdy_oe}, 8'h0F);
  endtask
  task automatic t_renumber();
    pulse(wake_cmd, 8'h00);
    chk8({6'h0, card_state}, 8'h01);
    pulse(wake_cmd, 8'h05);
    chk8({6'h0, card_state}, 8'h03);
    pulse(vendor_select_number_clear, 8'h00);
    pulse(reset_csn_cmd, 8'h00);
    chk8({csn[5:0], card_state}, 8'h03);
    pulse(wait_key_cmd, 8'h00);
    chk8({6'h0, card_state}, 8'h00);
    pnp_mode = 0;
    send_key(VENDOR_KEY, 32);
    pulse(wake_cmd, 8'h00);
    host.read_pair(1'b1, b);
    chk8({6'h0, card_state}, 8'h01);
  endtask
  initial begin
    mclk = 0;
    rst = 1;
    {addr_wr, wake_cmd, csn_wr, wait_key_cmd, reset_csn_cmd} = '0;
    vendor_select_number_clear = 0;
    wr_data = 8'h00;
    pnp_mode = 1;
    ready_req = 1;
    serial_id_in = 64'h1234_5678_9ABC_DEF0;
    exp_id = ident(serial_id_in);
    repeat (4) @(posedge mclk);
    #2 rst = 0;
    @(posedge mclk) #2;
    t_unlock();
    t_win();
    t_renumber();
    test_done();
  end
endmodule
bind pnp_isolation pnp_isolation_props chk (.*);
`default_nettype wire
